// *** pie_bank.sv ***
/*
 * Second peripheral interrupt enable bank with both peripheral priority
 * registers and the priority scheme switch, reached over a plain
 * strobe register port with read data one cycle after the read strobe.
 * Assumes pending flags of group two come from same-clock peripheral logic
 * and that vectoring logic elsewhere consumes the registered requests.
 */
// Chosen here: the register offsets and the plain strobed port.
// How it works
// - enable bank bits 7..5 read zero, writes there are dropped
// - bit 4 enables the nonvolatile write complete interrupt
// - bit 3 enables the bus collision interrupt
// - bit 2 enables the low voltage detect interrupt
// - bit 1 enables the auxiliary timer overflow interrupt
// - bit 0 enables the second capture/compare interrupt
// - one priority bit per peripheral source, held in two registers
// - priority bits matter only while the priority scheme enable is set
// - priority bit one means high, zero low; reset value is one
`timescale 1ns/100ps
`include "pie_regs.svh"

module pie_bank
    import pie_pkg::*;
#(
    parameter int NUM_SRC = `PIE_GRP2_N
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [`PIE_ADDR_W-1:0] regAddr,
    input wire logic [`PIE_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`PIE_DATA_W-1:0] regRdata,
    // pending flags of group two
    input wire logic [NUM_SRC-1:0] pendFlag,
    // enable and priority state for the rest of the controller
    output logic [NUM_SRC-1:0] irqEnable2,
    output logic [`PIE_DATA_W-1:0] irqPriority1,
    output logic [NUM_SRC-1:0] irqPriority2,
    output logic priorityScheme,
    // gated requests of group two
    output logic irqHigh,
    output logic irqLow
);

    // the field map is fixed at five sources; refuse anything else
    if (NUM_SRC != `PIE_GRP2_N) begin : g_chk
        $error("pie_bank: NUM_SRC must equal the five implemented enable bits");
    end

    pie_bus_s bus;
    pie_acc_e acc;
    pie_req_s gateReq;

    logic [NUM_SRC-1:0] enable2_q, enable2_d;
    logic [`PIE_DATA_W-1:0] prio1_q, prio1_d;
    logic [NUM_SRC-1:0] prio2_q, prio2_d;
    logic schemeEn_q, schemeEn_d;
    logic [`PIE_DATA_W-1:0] rdata_q, rdata_d;
    logic irqHigh_q, irqHigh_d;
    logic irqLow_q, irqLow_d;

    // bundle the port into one request word
    always_comb begin
        bus.addr = regAddr;
        bus.wdata = regWdata;
        bus.wr = regWr;
        bus.rd = regRd;
    end

    // classify the access; the master never raises both strobes together
    always_comb begin
        if (bus.wr) begin
            acc = PIE_ACC_WRITE;
        end else if (bus.rd) begin
            acc = PIE_ACC_READ;
        end else begin
            acc = PIE_ACC_IDLE;
        end
    end

    // register writes; only the implemented low bits are ever stored
    always_comb begin
        enable2_d = enable2_q;
        prio1_d = prio1_q;
        prio2_d = prio2_q;
        schemeEn_d = schemeEn_q;
        if (acc == PIE_ACC_WRITE) begin
            if (bus.addr == `PIE_OFS_ENABLE2) begin
                // upper three bits have no storage behind them
                enable2_d[`PIE_BIT_NVM_WRITE] = bus.wdata[`PIE_BIT_NVM_WRITE];
                enable2_d[`PIE_BIT_BUS_COLLISION] = bus.wdata[`PIE_BIT_BUS_COLLISION];
                enable2_d[`PIE_BIT_LOW_VOLTAGE] = bus.wdata[`PIE_BIT_LOW_VOLTAGE];
                enable2_d[`PIE_BIT_AUX_TIMER] = bus.wdata[`PIE_BIT_AUX_TIMER];
                enable2_d[`PIE_BIT_CAPCMP_B] = bus.wdata[`PIE_BIT_CAPCMP_B];
            end else if (bus.addr == `PIE_OFS_PRIO1) begin
                prio1_d = bus.wdata;
            end else if (bus.addr == `PIE_OFS_PRIO2) begin
                prio2_d = bus.wdata[`PIE_GRP2_MSB:0];
            end else if (bus.addr == `PIE_OFS_CTRL) begin
                schemeEn_d = bus.wdata[`PIE_BIT_SCHEME_EN];
            end
            // status and unmapped offsets ignore writes
        end
    end

    // read mux; unimplemented bits and unmapped offsets return zero
    always_comb begin
        rdata_d = `PIE_ZERO_BYTE;
        if (acc == PIE_ACC_READ) begin
            if (bus.addr == `PIE_OFS_ENABLE2) begin
                rdata_d[`PIE_GRP2_MSB:0] = enable2_q;
            end else if (bus.addr == `PIE_OFS_PRIO1) begin
                rdata_d = prio1_q;
            end else if (bus.addr == `PIE_OFS_PRIO2) begin
                rdata_d[`PIE_GRP2_MSB:0] = prio2_q;
            end else if (bus.addr == `PIE_OFS_CTRL) begin
                rdata_d[`PIE_BIT_SCHEME_EN] = schemeEn_q;
            end else if (bus.addr == `PIE_OFS_STATUS) begin
                // shows which sources are both pending and enabled right now
                rdata_d[`PIE_GRP2_MSB:0] = gateReq.active;
            end
        end
    end

    // gating uses the stored enables so a write takes effect the next cycle
    pie_src_gate #(
        .NUM_SRC(NUM_SRC)
    ) u_gate (
        .pendFlag(pendFlag),
        .srcEnable(enable2_q),
        .srcPrio(prio2_q),
        .schemeEnable(schemeEn_q),
        .gateReq(gateReq)
    );

    // requests are registered so the vectoring logic sees glitch-free levels
    always_comb begin
        irqHigh_d = gateReq.high;
        irqLow_d = gateReq.low;
    end

    // state registers; reset gives cleared enables and all-high priorities
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable2_q <= `PIE_RST_ENABLE2;
            prio1_q <= `PIE_RST_PRIO1;
            prio2_q <= `PIE_RST_PRIO2;
            schemeEn_q <= `PIE_RST_SCHEME_EN;
            rdata_q <= `PIE_ZERO_BYTE;
            irqHigh_q <= 1'b0;
            irqLow_q <= 1'b0;
        end else begin
            enable2_q <= enable2_d;
            prio1_q <= prio1_d;
            prio2_q <= prio2_d;
            schemeEn_q <= schemeEn_d;
            rdata_q <= rdata_d;
            irqHigh_q <= irqHigh_d;
            irqLow_q <= irqLow_d;
        end
    end

    // outputs straight from flip-flops
    assign regRdata = rdata_q;
    assign irqEnable2 = enable2_q;
    assign irqPriority1 = prio1_q;
    assign irqPriority2 = prio2_q;
    assign priorityScheme = schemeEn_q;
    assign irqHigh = irqHigh_q;
    assign irqLow = irqLow_q;

endmodule

// *** pie_regs.svh ***
/*
 * Register offsets, field positions and reset values of the second
 * peripheral interrupt enable bank, with its priority registers.
 * Assumes inclusion by bare name from the package and the main module.
 */
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH

// register bus geometry
`define PIE_ADDR_W 3
`define PIE_DATA_W 8

// register offsets
`define PIE_OFS_ENABLE2 3'h0
`define PIE_OFS_PRIO1 3'h1
`define PIE_OFS_PRIO2 3'h2
`define PIE_OFS_CTRL 3'h3
`define PIE_OFS_STATUS 3'h4

// enable bank two field positions
`define PIE_BIT_NVM_WRITE 4
`define PIE_BIT_BUS_COLLISION 3
`define PIE_BIT_LOW_VOLTAGE 2
`define PIE_BIT_AUX_TIMER 1
`define PIE_BIT_CAPCMP_B 0
`define PIE_GRP2_MSB 4
`define PIE_GRP2_N 5

// control register field positions
`define PIE_BIT_SCHEME_EN 0

// reset values
`define PIE_RST_ENABLE2 5'h00
`define PIE_RST_PRIO1 8'hFF
`define PIE_RST_PRIO2 5'h1F
`define PIE_RST_SCHEME_EN 1'h0

// read value of unimplemented or unmapped bits
`define PIE_ZERO_BYTE 8'h00

`endif

// *** pie_pkg.sv ***
/*
 * Types shared by the enable bank two block and its gating leaf.
 * Assumes pie_regs.svh is on the include path.
 */
`include "pie_regs.svh"

package pie_pkg;

    // register bus request from the core
    typedef struct packed {
        logic [`PIE_ADDR_W-1:0] addr;
        logic [`PIE_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pie_bus_s;

    // gated request of one source group
    typedef struct packed {
        logic high;
        logic low;
        logic [`PIE_GRP2_N-1:0] active;
    } pie_req_s;

    // decoded access kind
    typedef enum logic [1:0] {
        PIE_ACC_IDLE,
        PIE_ACC_WRITE,
        PIE_ACC_READ
    } pie_acc_e;

endpackage

// *** pie_src_gate.sv ***
/*
 * Per-source gating of pending flags by enable and priority bits.
 * Assumes flags, enables and priorities all come from the clk_sys domain.
 */
`timescale 1ns/100ps
`include "pie_regs.svh"

module pie_src_gate
    import pie_pkg::*;
#(
    parameter int NUM_SRC = `PIE_GRP2_N
) (
    // per-source inputs
    input wire logic [NUM_SRC-1:0] pendFlag,
    input wire logic [NUM_SRC-1:0] srcEnable,
    input wire logic [NUM_SRC-1:0] srcPrio,
    // global mode
    input wire logic schemeEnable,
    // gated result
    output pie_req_s gateReq
);

    logic [NUM_SRC-1:0] active;
    logic [NUM_SRC-1:0] highSel;

    // one gate per source; the flag itself is only read, never changed
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign active[i] = pendFlag[i] & srcEnable[i];
        // priority bits only steer when the scheme is on; otherwise all go high
        assign highSel[i] = active[i] & (srcPrio[i] | ~schemeEnable);
    end

    // collapse into one high and one low request for the vectoring logic
    always_comb begin
        gateReq = '0;
        gateReq.active = active;
        gateReq.high = |highSel;
        gateReq.low = |(active & ~highSel);
    end

endmodule

// *** pie_bank_properties.sv ***
/* checker for the enable bank two block: port relations over time.
   assumes one clk_sys domain and synchronous active-high rst. */
`timescale 1ns/100ps
`include "pie_regs.svh"
module pie_bank_properties
    import pie_pkg::*;
#(
    parameter int NUM_SRC = `PIE_GRP2_N
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [`PIE_ADDR_W-1:0] regAddr,
    input wire logic [`PIE_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [`PIE_DATA_W-1:0] regRdata,
    // flags and state
    input wire logic [NUM_SRC-1:0] pendFlag,
    input wire logic [NUM_SRC-1:0] irqEnable2,
    input wire logic [`PIE_DATA_W-1:0] irqPriority1,
    input wire logic [NUM_SRC-1:0] irqPriority2,
    input wire logic priorityScheme,
    input wire logic irqHigh,
    input wire logic irqLow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // active sources, one cycle ahead of the registered requests
    wire logic [NUM_SRC-1:0] act = pendFlag & irqEnable2;
    property p_rd_top; regRd && regAddr == 3'h0 |=> regRdata[7:5] == 3'h0; endproperty
    a_rd_top: assert property (p_rd_top) else $error("enable read upper bits set");
    property p_wr_en; regWr && regAddr == 3'h0 |=> irqEnable2 == $past(regWdata[4:0]); endproperty
    a_wr_en: assert property (p_wr_en) else $error("enable write lost");
    property p_rd_en; regRd && regAddr == 3'h0 |=> regRdata == {3'h0, $past(irqEnable2)}; endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable read wrong");
    property p_rd_idle; !regRd |=> regRdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_gate; act == 5'h00 |=> !irqHigh && !irqLow; endproperty
    a_gate: assert property (p_gate) else $error("request without enabled flag");
    property p_off; !priorityScheme && act != 5'h00 |=> irqHigh && !irqLow; endproperty
    a_off: assert property (p_off) else $error("priority used while scheme off");
    property p_high; priorityScheme && (act & irqPriority2) != 5'h00 |=> irqHigh; endproperty
    a_high: assert property (p_high) else $error("high request missing");
    property p_low; priorityScheme && (act & ~irqPriority2) != 5'h00 |=> irqLow; endproperty
    a_low: assert property (p_low) else $error("low request missing");
    property p_prio_wr; regWr && regAddr == 3'h2 |=> irqPriority2 == $past(regWdata[4:0]); endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("priority two write lost");
    property p_prio1_wr; regWr && regAddr == 3'h1 |=> irqPriority1 == $past(regWdata); endproperty
    a_prio1_wr: assert property (p_prio1_wr) else $error("priority one write lost");
    property p_scheme_wr; regWr && regAddr == 3'h3 |=> priorityScheme == $past(regWdata[0]); endproperty
    a_scheme_wr: assert property (p_scheme_wr) else $error("scheme write lost");
    // reset values are checked with reset itself as the cause
    property p_rst;
        @(posedge clk_sys) disable iff (1'b0)
        rst |=> irqEnable2 == 5'h00 && irqPriority2 == 5'h1F && irqPriority1 == 8'hFF;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    c_low: cover property (priorityScheme && irqLow);
    c_high: cover property (!priorityScheme && irqHigh);
    c_rd: cover property (regRd && regAddr == 3'h4);
endmodule
bind pie_bank pie_bank_properties #(.NUM_SRC(NUM_SRC)) u_pie_bank_properties (.*);

// *** pie_bank_bench.sv ***
/* self-checking bench for the enable bank two block.
   assumes the checker is bound in and a 100 MHz clk_sys. */
`timescale 1ns/100ps
`include "pie_regs.svh"
module pie_bank_bench
    import pie_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, irqHigh, irqLow, priorityScheme;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00, regRdata, irqPriority1;
    logic [4:0] pendFlag = 5'h00, irqEnable2, irqPriority2;
    int err_total = 0, samples_checked = 0, cyc = 0;
    pie_bank u_pie_bank (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pendFlag(pendFlag),
        .irqEnable2(irqEnable2), .irqPriority1(irqPriority1), .irqPriority2(irqPriority2),
        .priorityScheme(priorityScheme), .irqHigh(irqHigh), .irqLow(irqLow));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk("regRdata", regRdata, exp);
    endtask
    // flags change at an edge; the registered requests follow exactly one edge later
    task automatic irq(input logic [4:0] f, input logic h, input logic l);
        @(posedge clk_sys);
        pendFlag <= f;
        @(posedge clk_sys);
        #1 chk("irqHigh", {7'h00, irqHigh}, {7'h00, h});
        chk("irqLow", {7'h00, irqLow}, {7'h00, l});
    endtask
    // hang guard, well above the hundred or so cycles needed
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'hFF);
        rd(3'h2, 8'h1F);
        rd(3'h3, 8'h00);
        rd(3'h5, 8'h00);
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'h1F);
        wr(3'h1, 8'h5A);
        rd(3'h1, 8'h5A);
        chk("irqPriority1", irqPriority1, 8'h5A);
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, 8'h01 << i);
            irq(~(5'h01 << i), 1'b0, 1'b0);
            irq(5'h01 << i, 1'b1, 1'b0);
            rd(3'h4, 8'h01 << i);
        end
        wr(3'h3, 8'h01);
        wr(3'h2, 8'hEF);
        irq(5'h10, 1'b0, 1'b1);
        chk("priorityScheme", {7'h00, priorityScheme}, 8'h01);
        rd(3'h2, 8'h0F);
        chk("irqPriority2", {3'h0, irqPriority2}, 8'h0F);
        // one source routed high and one routed low at the same time
        wr(3'h0, 8'h11);
        irq(5'h11, 1'b1, 1'b1);
        wr(3'h3, 8'h00);
        irq(5'h11, 1'b1, 1'b0);
        wr(3'h4, 8'hFF);
        wr(3'h7, 8'hFF);
        rd(3'h0, 8'h11);
        chk("irqEnable2", {3'h0, irqEnable2}, 8'h11);
        wr(3'h0, 8'h00);
        irq(5'h11, 1'b0, 1'b0);
        // a mid-run reset must drop written enables and priorities back
        wr(3'h0, 8'h1F);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'hFF);
        rd(3'h2, 8'h1F);
        close_out();
    end
endmodule
